/* i2ccm_map.svh */
// Register offsets, field positions, reset values and timing counts of the
// command-driven two-wire bus master.
// Assumes inclusion by bare name from the master module and the bench.
`ifndef I2CCM_MAP_SVH
`define I2CCM_MAP_SVH

// ==========================================================================
// Register byte offsets on the APB port.
`define I2CCM_OFF_BIT_PERIOD 8'h00
`define I2CCM_OFF_COMMAND 8'h04
`define I2CCM_OFF_STATE 8'h08
`define I2CCM_OFF_TARGET 8'h0C
`define I2CCM_OFF_RX 8'h10
`define I2CCM_OFF_TX 8'h14
`define I2CCM_OFF_BUSY 8'h18

// ==========================================================================
// Reset values.
`define I2CCM_RST_BIT_PERIOD 8'h00
`define I2CCM_RST_BYTE 8'h00

// ==========================================================================
// Command bit positions.
`define I2CCM_CMD_START 5
`define I2CCM_CMD_STOP 4
`define I2CCM_CMD_ADDR 3
`define I2CCM_CMD_WRITE 2
`define I2CCM_CMD_RD_ACK 1
`define I2CCM_CMD_RD_NACK 0

// ==========================================================================
// Status codes.
`define I2CCM_ST_IDLE 8'h00
`define I2CCM_ST_START 8'h01
`define I2CCM_ST_RESTART 8'h02
`define I2CCM_ST_ADDR_ERR 8'hE4
`define I2CCM_ST_RD_ACK 8'h48
`define I2CCM_ST_RD_NACK 8'h28
`define I2CCM_ST_WR_ERR 8'hF0
`define I2CCM_ST_GEN_ERR 8'hFF
`define I2CCM_ST_ERR_BIT 7

// ==========================================================================
// Timing: one microsecond per unit, system clock period, four quarters a bit.
`define I2CCM_US_NS 1000
`define I2CCM_CLK_NS 50
`define I2CCM_CYC_PER_US ((`I2CCM_US_NS) / (`I2CCM_CLK_NS))
`define I2CCM_QTR_CYC ((`I2CCM_CYC_PER_US) / 4)

`endif

/* i2ccm_pkg.sv */
// Types shared by the two-wire bus master and its input synchroniser.
// Assumes the map header sits in the same folder.
package i2ccm_pkg;

  // ========================================================================
  // Engine states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_STOP = 2'b10,
    ST_BYTE = 2'b11
  } i2ccm_state_t;

  // ========================================================================
  // Kind of byte cycle in progress.
  typedef enum logic [1:0] {
    K_ADDR = 2'b00,
    K_WRITE = 2'b01,
    K_READ = 2'b10
  } i2ccm_kind_t;

  // ========================================================================
  // Levels of the two bus lines, carried together.
  typedef struct packed {
    logic scl;
    logic sda;
  } i2ccm_lines_t;

endpackage

/* i2ccm_sync.sv */
// Three-stage synchroniser and agreement filter for the bus line inputs.
// Assumes asynchronous pin levels; idle bus level is high.
`timescale 1ns/100ps
`default_nettype none

module i2ccm_sync
  import i2ccm_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Raw and filtered line levels.
  input wire i2ccm_lines_t raw,
  output i2ccm_lines_t filt
);

  logic [1:0] raw_v;
  logic [1:0] filt_v;

  assign raw_v = raw;
  assign filt = filt_v;

  // ========================================================================
  // Per line: three flops; the output follows once stages two and three agree.
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_line
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          s1 <= 1'b1;
          s2 <= 1'b1;
          s3 <= 1'b1;
          filt_v[i] <= 1'b1;
        end else begin
          s1 <= raw_v[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            filt_v[i] <= s3;
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* i2ccm_master.sv */
// Command-driven two-wire bus master with an APB register port.
// Assumes an APB master on clk_sys and pull-ups on both bus lines.
//
// Functional notes
// RL1: bit period in whole microseconds; zero blocks all bus activity; the code only refuses new commands at zero, a running one goes on.
// RL2: six commands, one bit each in the command register.
// RL3: command bit 5 sends start, or repeated start when open.
// RL4: command bit 4 sends stop and releases the bus.
// RL5: command bit 3 sends the whole target-select byte, then samples ack.
// RL6: command bit 2 sends the transmit byte, then samples ack.
// RL7: bit 1 receives a byte with ack; bit 0 receives with nack.
// RL8: receive register holds the latest byte read.
// RL9: status bits: error, nack, ack, write, read, address, restart, start; a read with ack sets bit 6, one with nack bit 5.
// RL10: start sets bit 0 from idle, bit 1 when already open.
// RL11: bits 2 to 6 encode phase, direction and ack of a byte cycle.
// RL12: errors set bit 7; a stop returns the block to idle.
// RL13: status byte takes the fixed codes of each outcome.
// RL14: target-select holds address in bits 7..1, direction in bit 0.
// RL15: transmit register keeps its byte for the next write command.
// RL16: software runs start, address, bytes, then stop.
// RL17: start is accepted anywhere in an open transfer as repeated start.
// RL18: software reads with ack except the last byte, read with nack.
// RL19: bit period register keeps its value from reset onward.
// RL20: timing derived from the system clock; lines driven open-drain.
// RL21: one command runs to completion; status shows the last outcome.
`include "i2ccm_map.svh"
`timescale 1ns/100ps
`default_nettype none

module i2ccm_master
  import i2ccm_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // APB slave port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bus lines, open-drain.
  input wire i2ccm_lines_t line_in,
  output i2ccm_lines_t line_out,
  output i2ccm_lines_t line_oe
);

  logic [7:0] bit_period;
  logic [7:0] transfer_state;
  logic [7:0] target_select;
  logic [7:0] receive_byte;
  logic [7:0] transmit_byte;
  logic busy;
  i2ccm_lines_t line_s;
  i2ccm_state_t state;
  i2ccm_kind_t kind;
  logic [1:0] qtr;
  logic [3:0] bitn;
  logic [7:0] shift;
  logic [10:0] tmr;
  logic open_xfer;
  logic addr_rnw;
  logic nack_cmd;
  logic ack_seen;

  // Every check in this module runs on the system clock and sleeps in reset.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // ========================================================================
  // Line input synchroniser.
  i2ccm_sync u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .raw(line_in),
    .filt(line_s)
  );

  // ========================================================================
  // APB decode: one wait state, writes land at the edge that sees pready.
  wire acc = psel & penable;
  wire wr_now = acc & pready & pwrite;
  wire sel_bp = paddr == `I2CCM_OFF_BIT_PERIOD;
  wire sel_cmd = paddr == `I2CCM_OFF_COMMAND;
  wire sel_st = paddr == `I2CCM_OFF_STATE;
  wire sel_tgt = paddr == `I2CCM_OFF_TARGET;
  wire sel_rx = paddr == `I2CCM_OFF_RX;
  wire sel_tx = paddr == `I2CCM_OFF_TX;
  wire sel_busy = paddr == `I2CCM_OFF_BUSY;
  wire mapped = sel_bp | sel_cmd | sel_st | sel_tgt | sel_rx | sel_tx |
                sel_busy;
  wire [7:0] rd_byte = sel_bp ? bit_period :
                       sel_st ? transfer_state :
                       sel_tgt ? target_select :
                       sel_rx ? receive_byte :
                       sel_tx ? transmit_byte :
                       sel_busy ? {7'h00, busy} : 8'h00;

  // Answer register: ready for one cycle after the first access cycle.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      prdata <= (acc & ~pready & ~pwrite) ? {24'h00_0000, rd_byte} :
                32'h0000_0000;
    end
  end

  // Software-written registers hold their values until rewritten.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bit_period <= `I2CCM_RST_BIT_PERIOD;
      target_select <= `I2CCM_RST_BYTE;
      transmit_byte <= `I2CCM_RST_BYTE;
    end else if (wr_now) begin
      if (sel_bp) bit_period <= pwdata[7:0]; // RL19
      if (sel_tgt) target_select <= pwdata[7:0]; // RL14
      if (sel_tx) transmit_byte <= pwdata[7:0]; // RL15
    end
  end

  // ========================================================================
  // Command decode: lowest set bit index loses to higher ones.
  wire [7:0] cmd = pwdata[7:0];
  wire cmd_wr = wr_now & sel_cmd;
  wire idle_ok = (state == ST_IDLE) & (bit_period != 8'h00); // RL1 RL21
  wire cmd_take = cmd_wr & idle_ok & (|cmd[5:0]); // RL2
  wire take_start = cmd[`I2CCM_CMD_START];
  wire take_stop = ~take_start & cmd[`I2CCM_CMD_STOP];
  wire take_addr = ~(|cmd[5:4]) & cmd[`I2CCM_CMD_ADDR];
  wire take_wr = ~(|cmd[5:3]) & cmd[`I2CCM_CMD_WRITE];
  wire take_rd = ~(|cmd[5:2]) & (|cmd[1:0]);
  wire take_rdn = ~cmd[`I2CCM_CMD_RD_ACK];
  wire in_err = transfer_state[`I2CCM_ST_ERR_BIT];
  wire take_byte = take_addr | take_wr | take_rd;
  wire cmd_bad = take_byte & (~open_xfer | in_err); // RL12

  // ========================================================================
  // Quarter-bit timer: bit period times five system cycles per quarter.
  wire [10:0] qlen_m1 = 11'(bit_period) * 11'(`I2CCM_QTR_CYC) - 11'd1; // RL20
  wire stretch = (qtr == 2'd1) & ~line_s.scl;
  wire adv = (state != ST_IDLE) & (tmr == 11'd0) & ~stretch;
  wire byte_fin = adv & (state == ST_BYTE) & (qtr == 2'd3) & (bitn == 4'd8);
  wire lost = adv & (state == ST_BYTE) & (qtr == 2'd1) & (bitn != 4'd8) &
              (kind != K_READ) & shift[7] & ~line_s.sda;
  wire [7:0] addr_code = {1'b0, ~ack_seen, ack_seen, ~addr_rnw, addr_rnw,
                          3'b100};
  wire [7:0] wr_code = {1'b0, ~ack_seen, ack_seen, 5'b10000};

  // Timer reloads on each command and after each quarter.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tmr <= 11'd0;
    end else if (cmd_take | adv) begin
      tmr <= qlen_m1;
    end else if (tmr != 11'd0) begin
      tmr <= tmr - 11'd1;
    end
  end

  // ========================================================================
  // Bus engine: actions happen at the end of each quarter of a bit.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      kind <= K_ADDR;
      qtr <= 2'd0;
      bitn <= 4'd0;
      shift <= 8'h00;
      open_xfer <= 1'b0;
      addr_rnw <= 1'b0;
      nack_cmd <= 1'b0;
      ack_seen <= 1'b0;
      transfer_state <= `I2CCM_ST_IDLE;
      receive_byte <= `I2CCM_RST_BYTE;
      line_oe <= '0;
    end else if (cmd_take) begin
      qtr <= 2'd0;
      bitn <= 4'd0;
      if (cmd_bad) begin
        transfer_state <= `I2CCM_ST_GEN_ERR; // RL12 RL13
      end else if (take_start) begin
        state <= ST_START; // RL3 RL17
        line_oe.sda <= 1'b0;
      end else if (take_stop & ~open_xfer) begin
        transfer_state <= `I2CCM_ST_IDLE; // RL12
      end else if (take_stop) begin
        state <= ST_STOP; // RL4
        line_oe.sda <= 1'b1;
      end else begin
        state <= ST_BYTE;
        kind <= take_addr ? K_ADDR : (take_wr ? K_WRITE : K_READ);
        shift <= take_addr ? target_select : transmit_byte; // RL5 RL6
        addr_rnw <= target_select[0]; // RL14
        nack_cmd <= take_rdn; // RL7
        line_oe.sda <= take_rd ? 1'b0 :
                       ~(take_addr ? target_select[7] : transmit_byte[7]);
      end
    end else if (lost) begin
      state <= ST_IDLE; // RL12
      open_xfer <= 1'b0;
      line_oe <= '0;
      transfer_state <= (kind == K_ADDR) ? `I2CCM_ST_ADDR_ERR :
                        `I2CCM_ST_WR_ERR;
    end else if (adv) begin
      qtr <= qtr + 2'd1;
      unique case (state)
        ST_START: begin
          unique case (qtr)
            2'd0: line_oe.scl <= 1'b0;
            2'd1: line_oe.sda <= 1'b1; // RL3
            2'd2: line_oe.scl <= 1'b1;
            2'd3: begin
              state <= ST_IDLE;
              open_xfer <= 1'b1;
              transfer_state <= open_xfer ? `I2CCM_ST_RESTART :
                                `I2CCM_ST_START; // RL10
            end
          endcase
        end
        ST_STOP: begin
          unique case (qtr)
            2'd0: line_oe.scl <= 1'b0;
            2'd1: line_oe.sda <= 1'b0; // RL4
            2'd2: line_oe <= '0;
            2'd3: begin
              state <= ST_IDLE;
              open_xfer <= 1'b0;
              transfer_state <= `I2CCM_ST_IDLE;
            end
          endcase
        end
        ST_BYTE: begin
          unique case (qtr)
            2'd0: line_oe.scl <= 1'b0;
            2'd1: begin
              if (bitn != 4'd8) begin
                shift <= {shift[6:0], line_s.sda};
              end else if (kind != K_READ) begin
                ack_seen <= ~line_s.sda; // RL5 RL6
              end
            end
            2'd2: line_oe.scl <= 1'b1;
            2'd3: begin
              if (bitn == 4'd8) begin
                state <= ST_IDLE;
                line_oe.sda <= 1'b0;
                unique case (kind)
                  K_ADDR: transfer_state <= addr_code; // RL11 RL13
                  K_WRITE: transfer_state <= wr_code; // RL11 RL13
                  default: begin
                    receive_byte <= shift; // RL8
                    transfer_state <= nack_cmd ? `I2CCM_ST_RD_NACK :
                                      `I2CCM_ST_RD_ACK; // RL9 RL11
                  end
                endcase
              end else begin
                bitn <= bitn + 4'd1;
                if (bitn == 4'd7) begin
                  line_oe.sda <= (kind == K_READ) & ~nack_cmd; // RL7
                end else begin
                  line_oe.sda <= (kind != K_READ) & ~shift[7];
                end
              end
            end
          endcase
        end
        ST_IDLE: state <= ST_IDLE;
      endcase
    end
  end

  // Line drivers only ever pull low; busy mirrors the engine.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      line_out <= '0; // RL20
      busy <= 1'b0;
    end else begin
      line_out <= '0;
      busy <= (state != ST_IDLE) | cmd_take;
    end
  end

  // ========================================================================
  // Checks on the engine and register port.
  sequence s_start_drop;
    (state == ST_START) && adv && (qtr == 2'd1);
  endsequence

  sequence s_start_end;
    (state == ST_START) && adv && (qtr == 2'd3);
  endsequence

  a_zero_period_idle: assert property ( // RL1
    (bit_period == 8'h00 && state == ST_IDLE) |=> state == ST_IDLE)
    else $error("Engine left idle with a zero bit period.");

  a_start_edge: assert property ( // RL3
    s_start_drop |=> line_oe.sda && !line_oe.scl)
    else $error("Start did not pull data low with clock released.");

  a_start_status: assert property ( // RL10
    s_start_end |=> open_xfer &&
      transfer_state == ($past(open_xfer) ? 8'h02 : 8'h01))
    else $error("Start status code wrong.");

  a_stop_release: assert property ( // RL4
    ((state == ST_STOP) && adv && (qtr == 2'd3)) |=>
      !line_oe.scl && !line_oe.sda && transfer_state == 8'h00)
    else $error("Stop did not release the bus.");

  a_addr_load: assert property ( // RL5
    (cmd_take && !cmd_bad && take_addr && !take_start && !take_stop) |=>
      state == ST_BYTE && shift == $past(target_select))
    else $error("Address command did not load the target byte.");

  a_addr_code: assert property ( // RL11
    (byte_fin && kind == K_ADDR) |=>
      transfer_state[2] && (transfer_state[5] != transfer_state[6]))
    else $error("Address completion code malformed.");

  a_rx_hold: assert property ( // RL8
    (byte_fin && kind == K_READ) |=> receive_byte == $past(shift))
    else $error("Received byte not stored.");

  a_busy_reject: assert property ( // RL21
    (state != ST_IDLE && cmd_wr) |=>
      (state == $past(state)) || (state == ST_IDLE))
    else $error("Command accepted while busy.");

  a_lost_error: assert property ( // RL12
    lost |=> transfer_state[7] && state == ST_IDLE)
    else $error("Lost data line did not flag an error.");

  a_period_keep: assert property ( // RL19
    !(wr_now && sel_bp) |=> $stable(bit_period))
    else $error("Bit period changed without a write.");

endmodule
`default_nettype wire

/* i2ccm_slave_model.sv */
// Behavioural two-wire slave that answers one seven-bit address.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/100ps
`default_nettype none

module i2ccm_slave_model #(
  parameter logic [6:0] ADDR = 7'h50,
  parameter logic [7:0] FIRST_RD = 8'hC5
) (
  // Resolved bus levels.
  input wire logic scl_b,
  input wire logic sda_b,
  // Data line pull and last byte written to us.
  output logic sda_pull,
  output logic [7:0] got
);
  // ==========================================================================
  // Frame tracking.
  logic [7:0] sh;
  logic [7:0] tx;
  logic act, sel, rd, first;
  int n;

  // Idle: data line released, nothing selected.
  initial begin
    sda_pull = 1'b0;
    got = 8'h00;
    sh = 8'h00;
    tx = FIRST_RD;
    {act, sel, rd, first} = 4'h0;
    n = 0;
  end

  // Start or repeated start opens an address byte.
  always @(negedge sda_b) if (scl_b === 1'b1) begin
    {act, sel, first} = 3'b101;
    n = 0;
    sda_pull = 1'b0;
  end

  // Stop closes the frame and lets the data line go.
  always @(posedge sda_b) if (scl_b === 1'b1) begin
    act = 1'b0;
    sda_pull = 1'b0;
  end

  // Sample data bits, and the master's answer after a byte we sent.
  always @(posedge scl_b) if (act) begin
    if (n < 8) sh = {sh[6:0], sda_b};
    if (n == 8 && sel && rd && !first) begin
      if (sda_b) sel = 1'b0;
      else tx = tx + 8'h11;
    end
    n = n + 1;
  end

  // Drive acknowledge or read data while the clock is low.
  always @(negedge scl_b) if (act) begin
    if (n == 9) begin
      n = 0;
      first = 1'b0;
    end
    if (n == 8) begin
      if (first) begin
        sel = (sh[7:1] == ADDR);
        rd = sh[0];
      end else if (sel && !rd) got = sh;
      sda_pull = sel && (first || !rd);
    end else sda_pull = sel && rd && !first && !tx[7-n];
  end
endmodule
`default_nettype wire

/* i2c_command_master_bench.sv */
// Self-checking bench for the command-driven two-wire bus master.
// Assumes the design package, map header and slave model are compiled first.
`include "i2ccm_map.svh"
`timescale 1ns/100ps
`default_nettype none

module i2c_command_master_bench import i2ccm_pkg::*;;
  // ==========================================================================
  // Design signals and bus resolution.
  logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, jam;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic er, sda_pull;
  logic [7:0] got;
  i2ccm_lines_t line_out, line_oe;
  int fail_count, checks_done;
  wire scl_b = !line_oe.scl;
  wire sda_b = !(line_oe.sda | sda_pull | jam);
  wire i2ccm_lines_t line_in = {scl_b, sda_b};

  i2ccm_master i2ccm_master_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_in(line_in), .line_out(line_out), .line_oe(line_oe));

  i2ccm_slave_model i2ccm_slave_model_i (.scl_b(scl_b), .sda_b(sda_b),
    .sda_pull(sda_pull), .got(got));

  // ==========================================================================
  // Shared tasks.
  // Compare and count; a mismatch is reported at once.
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer held until pready is sampled high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read a register and compare it.
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Issue a command, wait for the engine, then compare the status.
  task cmd(input logic [7:0] v, input logic [7:0] exp);
    apb(1'b1, `I2CCM_OFF_COMMAND, {24'h0, v});
    do begin
      apb(1'b0, `I2CCM_OFF_BUSY, 32'h0);
    end while (rd[0] !== 1'b0);
    rdc(`I2CCM_OFF_STATE, {24'h0, exp});
  endtask

  // ==========================================================================
  // Scenarios.
  // Reset values, read-back, unmapped access and the zero bit period.
  task t_regs;
    rdc(`I2CCM_OFF_BIT_PERIOD, 32'h0);
    cmd(8'h20, 8'h00);
    chk({30'h0, line_oe}, 32'h0);
    apb(1'b1, 8'h1C, 32'hFF);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, `I2CCM_OFF_BIT_PERIOD, 32'h01);
    rdc(`I2CCM_OFF_BIT_PERIOD, 32'h01);
    apb(1'b1, `I2CCM_OFF_TARGET, 32'hA0);
    rdc(`I2CCM_OFF_TARGET, 32'hA0);
    rdc(`I2CCM_OFF_COMMAND, 32'h0);
  endtask

  // Write a byte, switch direction by repeated start, read two bytes.
  task t_xfer;
    cmd(8'h20, 8'h01);
    cmd(8'h08, 8'h34);
    apb(1'b1, `I2CCM_OFF_TX, 32'h3C);
    cmd(8'h04, 8'h30);
    chk({24'h0, got}, 32'h3C);
    rdc(`I2CCM_OFF_TX, 32'h3C);
    cmd(8'h20, 8'h02);
    apb(1'b1, `I2CCM_OFF_TARGET, 32'hA1);
    cmd(8'h08, 8'h2C);
    cmd(8'h02, 8'h48);
    rdc(`I2CCM_OFF_RX, 32'hC5);
    cmd(8'h01, 8'h28);
    rdc(`I2CCM_OFF_RX, 32'hD6);
    cmd(8'h10, 8'h00);
    chk({30'h0, line_oe}, 32'h0);
    chk({30'h0, line_out}, 32'h0);
  endtask

  // Address nobody answers.
  task t_nack;
    apb(1'b1, `I2CCM_OFF_TARGET, 32'hB0);
    cmd(8'h20, 8'h01);
    cmd(8'h08, 8'h54);
    cmd(8'h04, 8'h50);
    cmd(8'h20, 8'h02);
    apb(1'b1, `I2CCM_OFF_TARGET, 32'hB1);
    cmd(8'h08, 8'h4C);
    cmd(8'h10, 8'h00);
  endtask

  // Data line held low during the address, then a refused write.
  task t_err;
    apb(1'b1, `I2CCM_OFF_TARGET, 32'hA0);
    cmd(8'h20, 8'h01);
    @(posedge clk_sys);
    jam <= 1'b1;
    cmd(8'h08, 8'hE4);
    @(posedge clk_sys);
    jam <= 1'b0;
    cmd(8'h04, 8'hFF);
    cmd(8'h10, 8'h00);
  endtask

  // Priority among set bits, empty commands, commands while busy.
  task t_prio;
    cmd(8'h30, 8'h01);
    cmd(8'h40, 8'h01);
    cmd(8'h18, 8'h00);
    apb(1'b1, `I2CCM_OFF_COMMAND, 32'h20);
    cmd(8'h10, 8'h01);
    cmd(8'h10, 8'h00);
  endtask

  // ==========================================================================
  // Verdict and run control.
  task summarize;
    if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Free-running system clock.
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Cut a hang short well past the expected run length.
  initial begin
    repeat (60000) @(posedge clk_sys);
    fail_count++;
    summarize;
  end

  // Main sequence.
  initial begin
    {arst_n, psel, penable, pwrite, jam} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fail_count = 0;
    checks_done = 0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_regs;
    t_xfer;
    t_nack;
    t_err;
    t_prio;
    summarize;
  end
endmodule
`default_nettype wire
